// ===== rtl/null_layer_pkg.sv
// constants for the null-layer and mixed-numerology extension parser
package null_layer_pkg;
    localparam logic [6:0] null_layer_type = 7'h0E;
    localparam logic [6:0] mixed_num_type = 7'h0F;
    localparam logic [7:0] null_layer_single_len = 8'h01;
    localparam logic [7:0] mixed_num_len = 8'h02;
    localparam logic [7:0] flag_scheduled = 8'h00;
    localparam logic [7:0] flag_nulling = 8'h01;
    localparam logic [3:0] sect_type_5 = 4'h5;
    localparam logic [3:0] sect_type_6 = 4'h6;
    localparam int follow_bit = 7;
    localparam int word_bytes = 4;
    localparam int carrier_shift_bytes = 3;
    localparam int guard_len_bytes = 2;
    localparam int fft_code_msb = 7;
    localparam int fft_code_lsb = 4;
endpackage

// ===== rtl/null_layer_numerology_ext_parser.sv
// parser for the null-layer and mixed-numerology section extensions
`timescale 1ns/1ps
module null_layer_numerology_ext_parser #(
    parameter int max_ports = 16,
    parameter int port_idx_w = 4
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic ext_start_i,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic [3:0] section_type_i,
    input wire logic grouped_port_present_i,
    input wire logic [port_idx_w-1:0] port_count_minus_one_i,
    input wire logic [max_ports-1:0] weight_valid_i,
    input wire logic [max_ports-1:0] user_data_valid_i,
    output logic byte_ready_o,
    output logic ext_done_o,
    output logic follow_o,
    output logic ext_error_o,
    output logic [max_ports-1:0] layer_nulling_flag_o,
    output logic [max_ports-1:0] weight_zero_o,
    output logic [max_ports-1:0] user_data_valid_o,
    output logic flags_valid_o,
    output logic numerology_valid_o,
    output logic [7:0] numerology_descriptor_o,
    output logic [23:0] carrier_shift_o,
    output logic [15:0] guard_prefix_length_o
);
    // ********************************************************
    // parse state
    // ********************************************************
    typedef enum {st_head, st_len, st_body, st_skip} state_t;

    state_t state;
    state_t next_state;
    logic [6:0] ext_type;
    logic [6:0] next_ext_type;
    logic follow;
    logic next_follow;
    logic [9:0] byte_idx;
    logic [9:0] next_byte_idx;
    logic [9:0] total_bytes;
    logic [9:0] next_total_bytes;
    logic [port_idx_w:0] flag_count;
    logic [port_idx_w:0] next_flag_count;
    logic apply;
    logic next_apply;
    logic [max_ports-1:0] flags;
    logic [max_ports-1:0] next_flags;
    logic [7:0] descriptor;
    logic [7:0] next_descriptor;
    logic [23:0] shift;
    logic [23:0] next_shift;
    logic [15:0] prefix;
    logic [15:0] next_prefix;
    logic done;
    logic next_done;
    logic err;
    logic next_err;
    logic fvalid;
    logic next_fvalid;
    logic nvalid;
    logic next_nvalid;
    logic [9:0] flag_pos;
    state_t cur_state;

    assign byte_ready_o = 1'b1;
    assign flag_pos = byte_idx - 10'd2;

    // ********************************************************
    // header strobe
    // ********************************************************
    // a start strobe makes the byte under it a header byte
    assign cur_state = ext_start_i ? st_head : state;

    // ********************************************************
    // next-state logic
    // ********************************************************
    always_comb
    begin
        next_state = state;
        next_ext_type = ext_type;
        next_follow = follow;
        next_byte_idx = byte_idx;
        next_total_bytes = total_bytes;
        next_flag_count = flag_count;
        next_apply = apply;
        next_flags = flags;
        next_descriptor = descriptor;
        next_shift = shift;
        next_prefix = prefix;
        next_done = 1'b0;
        next_err = err;
        next_fvalid = fvalid;
        next_nvalid = nvalid;
        if (ext_start_i)
        begin
            next_state = st_head;
            next_err = 1'b0;
        end
        if (byte_valid_i)
        begin
            next_byte_idx = byte_idx + 10'd1;
            case (cur_state)
                st_head:
                begin
                    next_follow = byte_i[null_layer_pkg::follow_bit];
                    next_ext_type = byte_i[6:0];
                    next_byte_idx = 10'd1;
                    next_state = st_len;
                end
                st_len:
                begin
                    // length in 4-byte words
                    next_total_bytes = {byte_i, 2'b00};
                    next_apply = 1'b0;
                    next_state = st_skip;
                    if (ext_type == null_layer_pkg::null_layer_type)
                    begin
                        next_apply = (section_type_i ==
                            null_layer_pkg::sect_type_5);
                        if (byte_i == null_layer_pkg::null_layer_single_len)
                            next_flag_count = (port_idx_w+1)'(1);
                        else if (grouped_port_present_i)
                            next_flag_count = {1'b0, port_count_minus_one_i}
                                + (port_idx_w+1)'(1);
                        else
                        begin
                            next_apply = 1'b0;
                            next_err = 1'b1;
                        end
                        if (next_apply)
                        begin
                            next_flags = '0;
                            next_fvalid = 1'b0;
                            next_state = st_body;
                        end
                    end
                    else if (ext_type == null_layer_pkg::mixed_num_type)
                    begin
                        next_apply = (section_type_i ==
                            null_layer_pkg::sect_type_5) ||
                            (section_type_i ==
                            null_layer_pkg::sect_type_6);
                        if (byte_i != null_layer_pkg::mixed_num_len)
                        begin
                            next_apply = 1'b0;
                            next_err = 1'b1;
                        end
                        if (next_apply)
                        begin
                            next_nvalid = 1'b0;
                            next_state = st_body;
                        end
                    end
                    // zero length cannot move on: flag it, back to header
                    if (byte_i == 8'h00)
                    begin
                        next_err = 1'b1;
                        next_state = st_head;
                        next_done = 1'b1;
                    end
                end
                st_body:
                begin
                    if (ext_type == null_layer_pkg::null_layer_type)
                    begin
                        if (flag_pos < 10'(flag_count) &&
                            flag_pos < 10'(max_ports))
                            // only value one nulls; others scheduled or
                            // reserved
                            next_flags[flag_pos[port_idx_w-1:0]] =
                                (byte_i == null_layer_pkg::flag_nulling);
                        if (flag_pos + 10'd1 == 10'(flag_count))
                            next_fvalid = 1'b1;
                    end
                    else
                    begin
                        if (byte_idx == 10'd2)
                            next_descriptor = byte_i;
                        else if (byte_idx < 10'd2 + 10'(
                            null_layer_pkg::carrier_shift_bytes + 1))
                            next_shift = {shift[15:0], byte_i};
                        else if (byte_idx < 10'd6 + 10'(
                            null_layer_pkg::guard_len_bytes))
                            next_prefix = {prefix[7:0], byte_i};
                        if (byte_idx == 10'd7)
                            next_nvalid = 1'b1;
                    end
                    if (byte_idx + 10'd1 == total_bytes)
                    begin
                        next_state = st_head;
                        next_done = 1'b1;
                    end
                end
                st_skip:
                begin
                    // padding and unknown bytes ignored
                    if (byte_idx + 10'd1 == total_bytes)
                    begin
                        next_state = st_head;
                        next_done = 1'b1;
                    end
                end
                default:
                    next_state = st_head;
            endcase
        end
    end

    // ********************************************************
    // state registers
    // ********************************************************
    always_ff @(posedge sys_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state <= st_head;
            ext_type <= 7'h00;
            follow <= 1'b0;
            byte_idx <= 10'h000;
            total_bytes <= 10'h000;
            flag_count <= '0;
            apply <= 1'b0;
            flags <= '0;
            descriptor <= 8'h00;
            shift <= 24'h000000;
            prefix <= 16'h0000;
            done <= 1'b0;
            err <= 1'b0;
            fvalid <= 1'b0;
            nvalid <= 1'b0;
        end
        else
        begin
            state <= next_state;
            ext_type <= next_ext_type;
            follow <= next_follow;
            byte_idx <= next_byte_idx;
            total_bytes <= next_total_bytes;
            flag_count <= next_flag_count;
            apply <= next_apply;
            flags <= next_flags;
            descriptor <= next_descriptor;
            shift <= next_shift;
            prefix <= next_prefix;
            done <= next_done;
            err <= next_err;
            fvalid <= next_fvalid;
            nvalid <= next_nvalid;
        end
    end

    // ********************************************************
    // per-layer nulling
    // ********************************************************
    genvar g;
    generate
        for (g = 0; g < max_ports; g++)
        begin : gen_layer
            // weights from valid channels only, zeroed once flagged and flags valid
            assign weight_zero_o[g] = fvalid & flags[g] &
                weight_valid_i[g];
            assign user_data_valid_o[g] = user_data_valid_i[g] &
                ~(fvalid & flags[g]);
        end
    endgenerate

    // ********************************************************
    // output drive
    // ********************************************************
    assign ext_done_o = done;
    assign follow_o = follow;
    assign ext_error_o = err;
    assign layer_nulling_flag_o = flags;
    assign flags_valid_o = fvalid;
    assign numerology_valid_o = nvalid;
    assign numerology_descriptor_o = descriptor;
    assign carrier_shift_o = shift;
    assign guard_prefix_length_o = prefix;
endmodule

// ===== tb/du_model.sv
// distributed-unit model feeding extension bytes
`timescale 1ns/1ps
module du_model (
    input wire logic sys_clk_i,
    input wire logic slow_i,
    output logic ext_start_o,
    output logic byte_valid_o,
    output logic [7:0] byte_o
);
    logic [8:0] fifo[$];
    logic [8:0] head;
    initial
    begin
        ext_start_o = 1'b0;
        byte_valid_o = 1'b0;
        byte_o = 8'h00;
    end
    // one byte per edge, random gaps when slow, idle line toggles
    always @(posedge sys_clk_i)
    begin
        if (fifo.size() > 0 && !(slow_i && $urandom_range(1) == 1))
        begin
            head = fifo.pop_front();
            ext_start_o <= head[8];
            byte_valid_o <= 1'b1;
            byte_o <= head[7:0];
        end
        else
        begin
            ext_start_o <= 1'b0;
            byte_valid_o <= 1'b0;
            byte_o <= ~byte_o;
        end
    end
endmodule

// ===== tb/null_layer_checker.sv
// port checker for the extension parser
`timescale 1ns/1ps
module null_layer_checker #(
    parameter int max_ports = 16,
    parameter int port_idx_w = 4
) (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic byte_valid_i,
    input wire logic [3:0] section_type_i,
    input wire logic [max_ports-1:0] weight_valid_i,
    input wire logic [max_ports-1:0] user_data_valid_i,
    input wire logic ext_done_o,
    input wire logic [max_ports-1:0] layer_nulling_flag_o,
    input wire logic [max_ports-1:0] weight_zero_o,
    input wire logic [max_ports-1:0] user_data_valid_o,
    input wire logic flags_valid_o,
    input wire logic numerology_valid_o,
    input wire logic [7:0] numerology_descriptor_o,
    input wire logic [23:0] carrier_shift_o,
    input wire logic [15:0] guard_prefix_length_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence done_blip;
        ext_done_o ##1 !ext_done_o;
    endsequence
    done_pulse_a: assert property (ext_done_o |-> done_blip)
        else $error("done longer than one cycle");
    done_cause_a: assert property (ext_done_o |-> $past(byte_valid_i))
        else $error("done without a byte");
    weight_zero_a: assert property (weight_zero_o == (flags_valid_o ?
        layer_nulling_flag_o & weight_valid_i : '0))
        else $error("weight zeroing wrong");
    no_user_data_a: assert property (user_data_valid_o ==
        (user_data_valid_i & ~(flags_valid_o ? layer_nulling_flag_o : '0)))
        else $error("user data on nulled layer");
    flags_gate_a: assert property ($changed(layer_nulling_flag_o) |->
        $past(section_type_i) == null_layer_pkg::sect_type_5)
        else $error("flags changed outside type 5");
    flags_rise_a: assert property ($rose(flags_valid_o) |->
        $past(byte_valid_i))
        else $error("flags valid without a byte");
    num_gate_a: assert property ($rose(numerology_valid_o) |->
        ext_done_o && $past(section_type_i) inside {4'h5, 4'h6})
        else $error("numerology taken in wrong type");
    num_hold_a: assert property (numerology_valid_o &&
        !$past(byte_valid_i) |-> $stable(carrier_shift_o) &&
        $stable(guard_prefix_length_o) && $stable(numerology_descriptor_o))
        else $error("numerology changed without a byte");
endmodule
bind null_layer_numerology_ext_parser null_layer_checker #(
    .max_ports(max_ports), .port_idx_w(port_idx_w)) chk_i (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i),
    .byte_valid_i(byte_valid_i), .section_type_i(section_type_i),
    .weight_valid_i(weight_valid_i),
    .user_data_valid_i(user_data_valid_i), .ext_done_o(ext_done_o),
    .layer_nulling_flag_o(layer_nulling_flag_o),
    .weight_zero_o(weight_zero_o),
    .user_data_valid_o(user_data_valid_o),
    .flags_valid_o(flags_valid_o),
    .numerology_valid_o(numerology_valid_o),
    .numerology_descriptor_o(numerology_descriptor_o),
    .carrier_shift_o(carrier_shift_o),
    .guard_prefix_length_o(guard_prefix_length_o));

// ===== tb/tb.sv
// testbench for the extension parser
`timescale 1ns/1ps
module tb;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic slow = 1'b0;
    logic ext_start, byte_valid, ready, done, follow, err, fvalid, nvalid;
    logic [7:0] byte_d, d, ed, desc_w;
    logic [3:0] sect = 4'h5;
    logic grouped = 1'b0;
    logic [3:0] pcnt = 4'h0;
    logic [15:0] wv = 16'h0000;
    logic [15:0] udv = 16'h0000;
    logic [15:0] nflag, wzero, udo, prefix, exp_flags, old, p, ep;
    logic [23:0] shift, s, es;
    int errors = 0;
    int compares = 0;
    always #25 sys_clk_i = ~sys_clk_i;
    du_model du (.sys_clk_i(sys_clk_i), .slow_i(slow),
        .ext_start_o(ext_start), .byte_valid_o(byte_valid), .byte_o(byte_d));
    null_layer_numerology_ext_parser dut (.sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i), .ext_start_i(ext_start),
        .byte_valid_i(byte_valid), .byte_i(byte_d), .section_type_i(sect),
        .grouped_port_present_i(grouped), .port_count_minus_one_i(pcnt),
        .weight_valid_i(wv), .user_data_valid_i(udv), .byte_ready_o(ready),
        .ext_done_o(done), .follow_o(follow), .ext_error_o(err),
        .layer_nulling_flag_o(nflag), .weight_zero_o(wzero),
        .user_data_valid_o(udo), .flags_valid_o(fvalid),
        .numerology_valid_o(nvalid), .numerology_descriptor_o(desc_w),
        .carrier_shift_o(shift), .guard_prefix_length_o(prefix));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic push(input logic [7:0] b, input logic first);
        du.fifo.push_back({first, b});
    endtask
    task automatic null_ext(input int n, input logic fol);
        logic [7:0] f;
        int words;
        words = (n + 5) / 4;
        exp_flags = 16'h0000;
        push({fol, 7'h0E}, 1'b1);
        push(8'(words), 1'b0);
        for (int k = 0; k < words * 4 - 2; k++)
        begin
            f = k < n ? 8'($urandom_range(2)) : 8'h00;
            if (k < n && f == 8'h01)
                exp_flags[k] = 1'b1;
            push(f, 1'b0);
        end
    endtask
    task automatic wait_ext(input logic need);
        int n;
        logic seen;
        n = 0;
        seen = 1'b0;
        while (du.fifo.size() > 0 && n < 200)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        repeat (4)
        begin
            @(negedge sys_clk_i);
            if (done === 1'b1)
                seen = 1'b1;
        end
        if (need)
            chk(32'(seen), 32'h1);
    endtask
    initial
    begin
        #1000000;
        errors++;
        give_verdict();
    end
    initial
    begin
        void'($urandom(49));
        repeat (20) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        @(negedge sys_clk_i);
        chk(32'({ready, done, fvalid, nvalid, err, nflag}), 32'h0010_0000);
        for (int i = 0; i < 24; i++)
        begin
            @(posedge sys_clk_i);
            slow <= i[0];
            grouped <= i > 2;
            pcnt <= 4'($urandom_range(15, 2));
            wv <= 16'($urandom);
            udv <= 16'($urandom);
            @(posedge sys_clk_i);
            null_ext(i > 2 ? int'(pcnt) + 1 : 1, 1'b0);
            wait_ext(1'b1);
            chk(32'({fvalid, nflag}), 32'({1'b1, exp_flags}));
            chk(32'(wzero), 32'(exp_flags & wv));
            chk(32'(udo), 32'(udv & ~exp_flags));
        end
        old = exp_flags;
        @(posedge sys_clk_i);
        sect <= 4'h6;
        grouped <= 1'b0;
        @(posedge sys_clk_i);
        null_ext(1, 1'b0);
        wait_ext(1'b1);
        chk(32'(nflag), 32'(old));
        @(posedge sys_clk_i);
        sect <= 4'h5;
        @(posedge sys_clk_i);
        null_ext(5, 1'b0);
        wait_ext(1'b1);
        chk(32'(err), 32'h1);
        null_ext(1, 1'b1);
        wait_ext(1'b1);
        chk(32'({follow, err}), 32'h2);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge sys_clk_i);
            sect <= i == 3 ? 4'h1 : 4'h5 + 4'(i % 2);
            @(posedge sys_clk_i);
            d = 8'($urandom);
            s = 24'($urandom);
            p = 16'($urandom);
            if (i == 1)
            begin
                d[7:4] = 4'h0;
                p = 16'h0000;
            end
            push(8'h0F, 1'b1);
            push(8'h02, 1'b0);
            push(d, 1'b0);
            push(s[23:16], 1'b0);
            push(s[15:8], 1'b0);
            push(s[7:0], 1'b0);
            push(p[15:8], 1'b0);
            push(p[7:0], 1'b0);
            wait_ext(1'b1);
            if (i != 3)
                {ed, es, ep} = {d, s, p};
            chk({desc_w, shift}, {ed, es});
            chk(32'({nvalid, prefix}), 32'({1'b1, ep}));
        end
        push(8'h0F, 1'b1);
        push(8'h00, 1'b0);
        wait_ext(1'b1);
        chk(32'(err), 32'h1);
        push(8'h0F, 1'b1);
        push(8'h01, 1'b0);
        push(8'h00, 1'b0);
        push(8'h00, 1'b0);
        wait_ext(1'b1);
        chk(32'({err, prefix}), 32'({1'b1, ep}));
        give_verdict();
    end
endmodule
